// *** verilog/sdd_pkg.sv ***
package sdd_pkg;

    // clock figures
    localparam int unsigned CLK_HZ     = 250_000_000; // ref_clk_i rate
    localparam int unsigned OSC_HZ     = 16_000_000;  // oscillator/crystal
    localparam int unsigned XTAL_DIV   = 8;           // 16 MHz down to mclk
    localparam int unsigned MCLK_HZ    = OSC_HZ / XTAL_DIV;
    localparam int unsigned MOD_HZ     = MCLK_HZ / 2; // modulator_rate
    localparam logic [2:0]  DIV_LAST   = 3'(XTAL_DIV - 1);

    // register byte offsets
    localparam logic [7:0]  REG_MODE   = 8'h00;
    localparam logic [7:0]  REG_FILT0  = 8'h04; // filter_config_reg, setup 0
    localparam logic [7:0]  REG_CHMAP  = 8'h20; // channel to setup map
    localparam logic [7:0]  REG_STAT   = 8'h24;
    localparam logic [7:0]  REG_MASK   = 8'h28;
    localparam logic [7:0]  REG_RES_LO = 8'h2C;
    localparam logic [7:0]  REG_RES_HI = 8'h30;

    // mode register fields
    localparam int unsigned MODE_SC_BIT  = 13; // single_cycle_settle_select
    localparam int unsigned MODE_CLK_LSB = 2;  // clock_source_select [3:2]
    localparam logic [15:0] MODE_RST     = 16'h0000;

    // filter configuration fields
    localparam int unsigned FILT_MAP_BIT  = 15; // sinc3 direct decimation
    localparam int unsigned FILT_TYPE_LSB = 5;  // filter type [6:5]
    localparam int unsigned FILT_ODR_LSB  = 0;  // rate code [3:0]
    localparam logic [15:0] FILT_RST      = 16'h0000;

    // status / mask bits
    localparam int unsigned ST_RDY     = 0; // result delivered
    localparam int unsigned ST_RESTART = 1; // filters restarted
    localparam logic [1:0]  STAT_RST   = 2'h0;

    // filter figures
    localparam logic [19:0] SINC5_DEC    = 20'h00020; // 1 MHz / 32
    localparam int unsigned S3_UNIT_LOG2 = 5;         // sinc3 step of 32
    localparam logic [14:0] SC_MIN_AVG   = 15'h000C;  // 2.6 kSPS and below
    localparam logic [2:0]  SINC5_PRIME  = 3'h4;      // sinc5 fill outputs
    localparam logic [1:0]  S3_SETTLE    = 2'h3;      // periods to settle
    localparam logic [14:0] ENH_AVG      = 15'h047A;  // 27.27 SPS

    // filter type encoding
    typedef enum logic [1:0] {
        SDD_FT_SINC51 = 2'h0,
        SDD_FT_ENH    = 2'h1,
        SDD_FT_RSV    = 2'h2,
        SDD_FT_SINC3  = 2'h3
    } sdd_filter_t;

    // clock source encoding
    typedef enum logic [1:0] {
        SDD_CS_INT  = 2'h0,
        SDD_CS_IOUT = 2'h1,
        SDD_CS_EXT  = 2'h2,
        SDD_CS_XTAL = 2'h3
    } sdd_clksrc_t;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } sdd_bus_req_t;

    // delivered conversion
    typedef struct packed {
        logic [2:0]  chan;
        logic [63:0] data;
    } sdd_result_t;

    // rate code to decimation count (sinc1 length or sinc3 step count)
    function automatic logic [14:0] sdd_odr_count(input logic [3:0] code);
        unique case (code)
            4'h0: sdd_odr_count = 15'h0001;
            4'h1: sdd_odr_count = 15'h0002;
            4'h2: sdd_odr_count = 15'h0003;
            4'h3: sdd_odr_count = 15'h0006;
            4'h4: sdd_odr_count = 15'h000C;
            4'h5: sdd_odr_count = 15'h001F;
            4'h6: sdd_odr_count = 15'h003E;
            4'h7: sdd_odr_count = 15'h0052;
            4'h8: sdd_odr_count = 15'h009C;
            4'h9: sdd_odr_count = 15'h0138;
            4'hA: sdd_odr_count = 15'h0209;
            4'hB: sdd_odr_count = 15'h0271;
            4'hC: sdd_odr_count = 15'h061A;
            4'hD: sdd_odr_count = 15'h0753;
            4'hE: sdd_odr_count = 15'h0C35;
            4'hF: sdd_odr_count = 15'h186A;
        endcase
    endfunction : sdd_odr_count

endpackage : sdd_pkg

// *** verilog/sdd_cic.sv ***
`timescale 1ns/10ps
// cascaded integrator-comb decimator of order ORD on a 1-bit stream
module sdd_cic #(
    parameter int unsigned ORD = 3,
    parameter int unsigned W   = 64,
    parameter int unsigned DW  = 20
) (
    // clock and reset
    input  wire logic          ref_clk_i,
    input  wire logic          sys_rst_i,
    // stream side
    input  wire logic          clear_i,
    input  wire logic          stb_i,
    input  wire logic          bit_i,
    input  wire logic [DW-1:0] dec_i,
    // decimated output
    output logic               vld_o,
    output logic [W-1:0]       out_o
);
    if (ORD < 1 || ORD > 8 || W < 8 || DW < 2) begin : g_chk
        $error("sdd_cic: unsupported parameters");
    end

    // whole filter state
    typedef struct packed {
        logic [ORD-1:0][W-1:0] integ; // integrator chain
        logic [ORD-1:0][W-1:0] dly;   // comb delay taps
        logic [DW-1:0]         cnt;   // decimation phase
        logic                  vld;
        logic [W-1:0]          out;
    } sdd_cic_state_t;

    sdd_cic_state_t c_q, c_d;
    logic [W-1:0]   x;   // comb stage carry
    logic [W-1:0]   y;

    // integrate each bit as +1/-1, comb once per decimation period
    always_comb begin
        c_d     = c_q;
        c_d.vld = 1'b0;
        x       = '0;
        y       = '0;
        if (clear_i) begin
            c_d = '0;
        end else if (stb_i) begin
            for (int k = ORD - 1; k > 0; k--) begin
                c_d.integ[k] = c_q.integ[k] + c_q.integ[k-1];
            end
            c_d.integ[0] = c_q.integ[0] + (bit_i ? W'(1) : '1);
            if (c_q.cnt >= DW'(dec_i - 1'b1)) begin
                c_d.cnt = '0;
                x = c_q.integ[ORD-1];
                for (int k = 0; k < ORD; k++) begin
                    y          = x - c_q.dly[k];
                    c_d.dly[k] = x;
                    x          = y;
                end
                c_d.out = x;
                c_d.vld = 1'b1;
            end else begin
                c_d.cnt = DW'(c_q.cnt + 1'b1);
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    assign vld_o = c_q.vld;
    assign out_o = c_q.out;

    // a clear empties the filter before anything more comes out
    cic_clear_empty_a : assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        clear_i |=> !vld_o && c_q.cnt == '0 && c_q.integ == '0)
        else $error("filter not empty after clear");

endmodule : sdd_cic

// *** verilog/sdd_top.sv ***
`timescale 1ns/10ps
// What this block does
// - sinc5+sinc1, sinc3 and 50/60 Hz filter types
// - filter and rate come from channel's setup
// - sinc5 fixed at 31.25 kSPS, sinc1 sets rate
// - sinc5+sinc1 settles in one period below 2.6k
// - sinc3 settling equals three output periods
// - direct bit makes low 15 bits decimation
// - direct rate is modulator rate over 32 times value
// - single-cycle mode outputs only settled results
// - single-cycle ignored for sinc5+sinc1 at 2.6k
// - sinc3 step needs three periods unless single-cycle
// - ready pulses once per settling interval in single-cycle mode
// - external clock pin drives master clock directly
// - crystal on crystal pins can source clock
// - 16 MHz source divided by eight to mclk
// - two-bit clock source field, internal by default
module sdd_top #(
    parameter int unsigned NUM_CHAN  = 2,
    parameter int unsigned NUM_SETUP = 2
) (
    // clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 sys_rst_i,
    // register port
    input  wire sdd_pkg::sdd_bus_req_t bus_i,
    output logic [31:0]               rdata_o,
    output logic                      irq_o,
    // clock sources
    input  wire logic                 osc_tick_i,
    input  wire logic                 crystal_in_pin_i,
    input  wire logic                 crystal_out_clock_io_pin_i,
    output logic [1:0]                clk_src_o,
    // modulator side
    output logic                      mod_stb_o,
    input  wire logic                 mod_bit_i,
    input  wire logic [2:0]           chan_i,
    // results
    output logic                      rdy_o,
    output sdd_pkg::sdd_result_t      result_o
);
    localparam int unsigned SW = (NUM_SETUP > 1) ? $clog2(NUM_SETUP) : 1;

    if (NUM_CHAN < 1 || NUM_CHAN > 8 || NUM_SETUP < 1 || NUM_SETUP > 7
        || NUM_CHAN * SW > 32) begin : g_chk
        $error("sdd_top: unsupported channel or setup count");
    end

    // whole block state
    typedef struct packed {
        logic [15:0]                 mode;   // mode register
        logic [NUM_SETUP-1:0][15:0]  filt;   // one filter config per setup
        logic [NUM_CHAN-1:0][SW-1:0] chmap;  // setup of each channel
        logic [1:0]                  stat;   // sticky events
        logic [1:0]                  mask;
        logic [31:0]                 rdata;
        logic [2:0]                  div;    // divide-by-eight phase
        logic                        half;   // modulator half-rate phase
        logic                        ext_prev;
        logic                        xtal_prev;
        logic                        mtick;  // master clock tick
        logic                        mstb;   // modulator sample strobe
        logic                        mbit;
        logic [2:0]                  chan;   // channel being converted
        logic                        clr;    // restart filters
        logic [63:0]                 acc;    // sinc1 sum
        logic [14:0]                 s1_cnt;
        logic [2:0]                  prime;  // sinc5 outputs to drop
        logic [1:0]                  s3_cnt;
        logic                        rdy;
        sdd_pkg::sdd_result_t        res;
        logic                        irq;
    } sdd_state_t;

    sdd_state_t           s_q, s_d;
    logic [SW-1:0]        cur_set;  // setup of current channel
    logic [15:0]          cur_filt;
    logic                 direct;   // sinc3 direct decimation
    sdd_pkg::sdd_filter_t ftype;
    logic [14:0]          dec15;    // sinc3 steps of 32
    logic [14:0]          avg;      // sinc1 length
    logic                 sc;       // single-cycle settling requested
    logic                 s5_gate;  // single-cycle has effect on sinc5
    sdd_pkg::sdd_clksrc_t clksel;
    logic                 ext_edge;
    logic                 xtal_edge;
    logic                 c5_vld;
    logic [31:0]          c5_out;
    logic                 c3_vld;
    logic [63:0]          c3_out;
    logic [1:0]           st_set;
    logic [1:0]           w1c;
    logic                 emit;
    logic [63:0]          emit_val;

    assign cur_set  = s_q.chmap[s_q.chan % NUM_CHAN];
    assign cur_filt = s_q.filt[cur_set];
    assign direct   = cur_filt[sdd_pkg::FILT_MAP_BIT];
    assign ftype    = direct ? sdd_pkg::SDD_FT_SINC3
                    : sdd_pkg::sdd_filter_t'(
                        cur_filt[sdd_pkg::FILT_TYPE_LSB +: 2]);
    // decimation value, zero held at one
    assign dec15    = direct
                    ? ((cur_filt[14:0] == 15'h0000) ? 15'h0001
                                                    : cur_filt[14:0])
                    : sdd_pkg::sdd_odr_count(
                        cur_filt[sdd_pkg::FILT_ODR_LSB +: 4]);
    // enhanced rejection uses a fixed sinc1 length
    assign avg      = (ftype == sdd_pkg::SDD_FT_ENH) ? sdd_pkg::ENH_AVG
                    : sdd_pkg::sdd_odr_count(
                        cur_filt[sdd_pkg::FILT_ODR_LSB +: 4]);
    assign sc       = s_q.mode[sdd_pkg::MODE_SC_BIT];
    // no effect at long sinc1 lengths
    assign s5_gate  = sc && (avg < sdd_pkg::SC_MIN_AVG);
    assign clksel   = sdd_pkg::sdd_clksrc_t'(
                        s_q.mode[sdd_pkg::MODE_CLK_LSB +: 2]);
    assign ext_edge  = crystal_out_clock_io_pin_i && !s_q.ext_prev;
    assign xtal_edge = crystal_in_pin_i && !s_q.xtal_prev;

    sdd_cic #(.ORD(5), .W(32), .DW(20)) u_sinc5 (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .clear_i   (s_q.clr),
        .stb_i     (s_q.mstb),
        .bit_i     (s_q.mbit),
        .dec_i     (sdd_pkg::SINC5_DEC),
        .vld_o     (c5_vld),
        .out_o     (c5_out)
    );

    // sinc3 stage at 32 times programmed value
    sdd_cic #(.ORD(3), .W(64), .DW(20)) u_sinc3 (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .clear_i   (s_q.clr),
        .stb_i     (s_q.mstb),
        .bit_i     (s_q.mbit),
        .dec_i     ({dec15, 5'h00}),
        .vld_o     (c3_vld),
        .out_o     (c3_out)
    );

    // next state: clocks, register port, rate control
    always_comb begin
        s_d      = s_q;
        s_d.rdy  = 1'b0;
        s_d.clr  = 1'b0;
        s_d.rdata = '0;
        st_set   = 2'h0;
        w1c      = 2'h0;
        emit     = 1'b0;
        emit_val = '0;

        // source edges
        s_d.ext_prev  = crystal_out_clock_io_pin_i;
        s_d.xtal_prev = crystal_in_pin_i;
        s_d.mtick     = 1'b0;
        unique case (clksel)
            // external pin edge is the master clock
            sdd_pkg::SDD_CS_EXT: s_d.mtick = ext_edge;
            sdd_pkg::SDD_CS_XTAL: begin
                if (xtal_edge) begin
                    s_d.div   = 3'(s_q.div + 1'b1);
                    s_d.mtick = (s_q.div == sdd_pkg::DIV_LAST);
                end
            end
            sdd_pkg::SDD_CS_INT, sdd_pkg::SDD_CS_IOUT: begin
                if (osc_tick_i) begin
                    s_d.div   = 3'(s_q.div + 1'b1);
                    s_d.mtick = (s_q.div == sdd_pkg::DIV_LAST);
                end
            end
        endcase
        // modulator at half the master clock
        s_d.mstb = s_q.mtick && s_q.half;
        if (s_q.mtick) begin
            s_d.half = !s_q.half;
        end
        if (s_q.mtick && s_q.half) begin
            s_d.mbit = mod_bit_i;
        end

        // register writes
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                sdd_pkg::REG_MODE: begin
                    s_d.mode = bus_i.wdata[15:0];
                    s_d.clr  = 1'b1;
                end
                sdd_pkg::REG_CHMAP: begin
                    s_d.chmap = bus_i.wdata[NUM_CHAN*SW-1:0];
                    s_d.clr   = 1'b1;
                end
                sdd_pkg::REG_STAT: w1c      = bus_i.wdata[1:0];
                sdd_pkg::REG_MASK: s_d.mask = bus_i.wdata[1:0];
                default: ;
            endcase
            for (int k = 0; k < NUM_SETUP; k++) begin
                if (bus_i.addr == 8'(sdd_pkg::REG_FILT0 + 4 * k)) begin
                    s_d.filt[k] = bus_i.wdata[15:0];
                    s_d.clr     = 1'b1;
                end
            end
        end

        // register reads, data in the next cycle only
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                sdd_pkg::REG_MODE:   s_d.rdata = {16'h0000, s_q.mode};
                sdd_pkg::REG_CHMAP:  s_d.rdata = 32'(s_q.chmap);
                sdd_pkg::REG_STAT:   s_d.rdata = {30'h0, s_q.stat};
                sdd_pkg::REG_MASK:   s_d.rdata = {30'h0, s_q.mask};
                sdd_pkg::REG_RES_LO: s_d.rdata = s_q.res.data[31:0];
                sdd_pkg::REG_RES_HI: s_d.rdata = s_q.res.data[63:32];
                default: ;
            endcase
            for (int k = 0; k < NUM_SETUP; k++) begin
                if (bus_i.addr == 8'(sdd_pkg::REG_FILT0 + 4 * k)) begin
                    s_d.rdata = {16'h0000, s_q.filt[k]};
                end
            end
        end

        // channel change restarts the filters
        if (chan_i != s_q.chan) begin
            s_d.chan = chan_i;
            s_d.clr  = 1'b1;
        end

        if (s_q.clr) begin
            s_d.acc    = '0;
            s_d.s1_cnt = '0;
            s_d.s3_cnt = '0;
            // first sinc5 outputs are not settled
            s_d.prime  = s5_gate ? sdd_pkg::SINC5_PRIME : 3'h0;
            st_set[sdd_pkg::ST_RESTART] = 1'b1;
        end else if (ftype == sdd_pkg::SDD_FT_SINC3) begin
            if (c3_vld) begin
                if (sc) begin
                    if (s_q.s3_cnt == 2'(sdd_pkg::S3_SETTLE - 1'b1)) begin
                        s_d.s3_cnt = 2'h0;
                        emit       = 1'b1;
                    end else begin
                        s_d.s3_cnt = 2'(s_q.s3_cnt + 1'b1);
                    end
                end else begin
                    emit = 1'b1;
                end
                emit_val = c3_out;
            end
        end else if (c5_vld) begin
            if (s_q.prime != 3'h0) begin
                s_d.prime = 3'(s_q.prime - 1'b1);
            end else if (s_q.s1_cnt >= 15'(avg - 1'b1)) begin
                // emit and refill the window when gated
                emit       = 1'b1;
                emit_val   = s_q.acc + 64'(signed'(c5_out));
                s_d.acc    = '0;
                s_d.s1_cnt = '0;
                s_d.prime  = s5_gate ? sdd_pkg::SINC5_PRIME : 3'h0;
            end else begin
                s_d.acc    = s_q.acc + 64'(signed'(c5_out));
                s_d.s1_cnt = 15'(s_q.s1_cnt + 1'b1);
            end
        end

        if (emit) begin
            s_d.rdy      = 1'b1;
            s_d.res.data = emit_val;
            s_d.res.chan = s_q.chan;
            st_set[sdd_pkg::ST_RDY] = 1'b1;
        end

        // sticky status, a new event beats the clear
        s_d.stat = (s_q.stat & ~w1c) | st_set;
        s_d.irq  = |(s_d.stat & s_d.mask);
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_q       <= '0;
            s_q.mode  <= sdd_pkg::MODE_RST;
            s_q.filt  <= {NUM_SETUP{sdd_pkg::FILT_RST}};
            s_q.stat  <= sdd_pkg::STAT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign rdata_o   = s_q.rdata;
    assign irq_o     = s_q.irq;
    assign clk_src_o = s_q.mode[sdd_pkg::MODE_CLK_LSB +: 2];
    assign mod_stb_o = s_q.mstb;
    assign rdy_o     = s_q.rdy;
    assign result_o  = s_q.res;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence ext_edge_s;
        clksel == sdd_pkg::SDD_CS_EXT && ext_edge;
    endsequence
    sequence s3_third_s;
        !s_q.clr && ftype == sdd_pkg::SDD_FT_SINC3 && sc && c3_vld
        && s_q.s3_cnt == 2'h2;
    endsequence

    ext_clock_a : assert property (ext_edge_s |=> s_q.mtick)
        else $error("external edge gave no master tick");
    // eight oscillator ticks per master tick
    div_eight_a : assert property (
        s_q.mtick && clksel == $past(clksel) && clksel != sdd_pkg::SDD_CS_EXT
        |-> $past(s_q.div) == 3'h7)
        else $error("master tick not on eighth source tick");
    // modulator strobe every second master tick
    mod_half_a : assert property (s_q.mstb |-> $past(s_q.mtick)
        && $past(s_q.half))
        else $error("modulator strobe off half rate");
    direct_dec_a : assert property (direct && cur_filt[14:0] != 15'h0000
        |-> dec15 == cur_filt[14:0] && ftype == sdd_pkg::SDD_FT_SINC3)
        else $error("direct decimation not applied");
    s3_ready_a : assert property (s3_third_s |=> rdy_o ##1 !rdy_o)
        else $error("single-cycle sinc3 ready missing");
    // no ready on the skipped sinc3 outputs
    s3_skip_a : assert property (
        !s_q.clr && ftype == sdd_pkg::SDD_FT_SINC3
        && sc && c3_vld && s_q.s3_cnt != 2'h2 |=> !rdy_o)
        else $error("unsettled sinc3 result delivered");
    s5_noprime_a : assert property (s_q.clr && avg >= sdd_pkg::SC_MIN_AVG
        |=> s_q.prime == 3'h0)
        else $error("single-cycle acted on slow sinc5 path");
    reset_clk_a : assert property (
        $past(sys_rst_i) |-> clk_src_o == 2'h0)
        else $error("clock source not internal after reset");
    ready_chan_a : assert property (
        rdy_o |-> result_o.chan == $past(s_q.chan))
        else $error("result channel mismatch");
    // interrupt follows masked status
    irq_level_a : assert property (irq_o == |(s_q.stat & s_q.mask))
        else $error("interrupt level wrong");

endmodule : sdd_top

// *** tb/sdd_mod_model.sv ***
`timescale 1ns/10ps
// modulator and clock sources facing the converter
module sdd_mod_model (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    // modulator sample moment
    input  wire logic mod_stb_i,
    // clock pins and bit stream
    output logic      osc_tick_o,
    output logic      xtal_o,
    output logic      ext_clk_o,
    output logic      mod_bit_o
);
    logic [1:0] ph_q; // free running phase
    always_ff @(posedge ref_clk_i) begin
        ph_q       <= sys_rst_i ? 2'h0 : ph_q + 2'h1;
        osc_tick_o <= ph_q[0];
        xtal_o     <= ~ph_q[0];
        ext_clk_o  <= ph_q[1];
        // input step: low from reset, high after first sample
        if (sys_rst_i) mod_bit_o <= 1'b0;
        else if (mod_stb_i) mod_bit_o <= 1'b1;
    end
endmodule : sdd_mod_model

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
// bench for rate, filter and clock source control
module tb_top;
    // stimulus, outputs and counters
    logic                  ref_clk_i = 1'b0;
    logic                  sys_rst_i = 1'b1;
    sdd_pkg::sdd_bus_req_t bus_i     = '0;
    logic [2:0]            chan_i    = 3'h0;
    logic [31:0]           rdata_o, d;
    logic [1:0]            clk_src_o;
    logic                  irq_o, osc, xtal, ext, mstb, mbit, rdy_o;
    sdd_pkg::sdd_result_t  result_o;
    int                    n_errors  = 0;
    int                    tests_run = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    sdd_top uut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .irq_o(irq_o), .osc_tick_i(osc),
        .crystal_in_pin_i(xtal), .crystal_out_clock_io_pin_i(ext),
        .clk_src_o(clk_src_o), .mod_stb_o(mstb), .mod_bit_i(mbit),
        .chan_i(chan_i), .rdy_o(rdy_o), .result_o(result_o));
    sdd_mod_model modl (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .mod_stb_i(mstb),
        .osc_tick_o(osc), .xtal_o(xtal), .ext_clk_o(ext), .mod_bit_o(mbit));
    // verdict and end of run
    task automatic summarize();
        $display("errors %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    // compare and count
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        bus_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_i);
        bus_i.wr <= 1'b0;
    endtask : wr
    // one-cycle register read, data the cycle after
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_i);
        bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_i);
        bus_i.rd <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    // bounded wait for a result, counting samples
    task automatic wait_rdy(output int s);
        int k;
        s = 0;
        k = 0;
        do begin
            @(posedge ref_clk_i);
            s += int'(mstb);
            k++;
            if (k > 20000) begin
                check(1'b1, 1'b0);
                summarize();
            end
        end while (rdy_o !== 1'b1);
    endtask : wait_rdy
    // samples between two results
    task automatic span(input int exp);
        int s;
        // the first interval may still hold a result of the old setup
        repeat (3) wait_rdy(s);
        check(s, exp);
    endtask : span
    // source edges per modulator sample, internal, crystal and external sources
    task automatic t_clk();
        logic [1:0] src [3] = '{2'h0, 2'h3, 2'h2};
        int         per [3] = '{16, 16, 2};
        int         n, k;
        logic       cur, last;
        foreach (src[i]) begin
            wr(sdd_pkg::REG_MODE, {28'h0, src[i], 2'h0});
            repeat (4) @(posedge ref_clk_i);
            check(clk_src_o, src[i]);
            k = 0;
            while (mstb !== 1'b1 && k < 999) begin
                @(posedge ref_clk_i);
                k++;
            end
            last = (i == 0) ? osc : (i == 1) ? xtal : ext;
            n = 0;
            do begin
                @(posedge ref_clk_i);
                cur = (i == 0) ? osc : (i == 1) ? xtal : ext;
                n += int'(cur & ~last);
                last = cur;
                k++;
            end while (mstb !== 1'b1 && k < 999);
            if (k >= 999) begin
                check(1'b1, 1'b0);
                summarize();
            end
            check(n, per[i]);
        end
    endtask : t_clk
    // reset values and unmapped address
    task automatic t_reset();
        check(clk_src_o, 2'h0);
        rd(sdd_pkg::REG_MODE);
        check(d, 32'h0);
        rd(8'hFC);
        check(d, 32'h0);
    endtask : t_reset
    // filter types, direct decimation, single-cycle mode
    task automatic t_filt();
        wr(sdd_pkg::REG_MODE, 32'h0000_0008);
        span(32);
        wr(sdd_pkg::REG_MODE, 32'h0000_2008);
        span(160);
        wr(sdd_pkg::REG_FILT0, 32'h0000_0004);
        wr(sdd_pkg::REG_MODE, 32'h0000_2008);
        span(384);
        wr(sdd_pkg::REG_FILT0, 32'h0000_8003);
        span(288);
        // all-ones stream: a settled sinc3 sum is 96 cubed
        check(result_o.data, 64'h0000_0000_000D_8000);
        rd(sdd_pkg::REG_RES_LO);
        check(d, 32'h000D_8000);
        rd(sdd_pkg::REG_RES_HI);
        check(d, 32'h0);
        wr(sdd_pkg::REG_MODE, 32'h0000_0008);
        span(96);
        wr(sdd_pkg::REG_FILT0, 32'h0000_0061);
        span(64);
        check(result_o.chan, 3'h0);
    endtask : t_filt
    // second channel on its own setup
    task automatic t_setup();
        wr(sdd_pkg::REG_CHMAP, 32'h0000_0002);
        wr(sdd_pkg::REG_FILT0 + 8'h04, 32'h0000_0001);
        chan_i <= 3'h1;
        span(64);
        check(result_o.chan, 3'h1);
    endtask : t_setup
    // status, mask and interrupt level
    task automatic t_irq();
        int s;
        wait_rdy(s);
        repeat (3) @(posedge ref_clk_i);
        #1 check(irq_o, 1'b0);
        wr(sdd_pkg::REG_MASK, 32'h1);
        repeat (2) @(posedge ref_clk_i);
        #1 check(irq_o, 1'b1);
        rd(sdd_pkg::REG_STAT);
        check(d[0], 1'b1);
        wr(sdd_pkg::REG_STAT, 32'h3);
        repeat (2) @(posedge ref_clk_i);
        #1 check(irq_o, 1'b0);
    endtask : t_irq
    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_clk();
        t_filt();
        t_setup();
        t_irq();
        summarize();
    end
endmodule : tb_top
